// *** src/ebd_core.sv ***
// External bus area decode, bus sizing and external cycle sequencing
`timescale 1ns/100ps
`default_nettype none
`include "ebd_defines.svh"

module ebd_core #(
  parameter ebd_pkg::ebd_variant_t VARIANT = ebd_pkg::EBD_VAR_FOUR, // Device variant
  parameter int unsigned           WAITS   = 0                      // Wait states n
) (
  input  wire logic              hclk,        // System clock
  input  wire logic              hresetn,     // Async reset, low
  input  wire logic              hsel,        // AHB select
  input  wire logic [31:0]       haddr,       // AHB address
  input  wire logic [1:0]        htrans,      // AHB transfer type
  input  wire logic              hwrite,      // AHB write
  input  wire logic [2:0]        hsize,       // AHB size
  input  wire logic [31:0]       hwdata,      // AHB write data
  input  wire logic              hready,      // AHB bus ready
  output logic [31:0]            hrdata,      // AHB read data
  output logic                   hreadyout,   // AHB slave ready
  output logic                   hresp,       // AHB response
  input  wire ebd_pkg::ebd_req_t req,         // CPU access request
  output logic                   req_ready,   // Request accepted
  output logic                   done,        // Access finished pulse
  output logic [31:0]            rdata,       // Assembled read data
  input  wire logic [15:0]       ext_data_in, // External data pins in
  output ebd_pkg::ebd_pins_t     pins         // External bus pins
);
  import ebd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CYC  = 3'b010,
    ST_DONE = 3'b100
  } ebd_state_t;

  logic [15:0]  area_width_config;
  logic [7:0]   bus_mode_control;
  logic         wr_pend;
  logic         rd_pend;
  logic [31:0]  bus_addr;
  ebd_state_t   state;
  ebd_req_t     cur;
  logic [1:0]   part;
  logic [1:0]   nparts;
  logic [2:0]   clk_cnt;
  logic [2:0]   cyc_len;
  logic [3:0]   sel_dec;
  logic [27:0]  eff_addr;
  logic         wide16;
  logic [1:0]   next_nparts;
  logic [27:0]  part_addr;
  logic         separate_mode_select;

  // AHB address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      bus_addr <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend  <= hsel && htrans[1] && hwrite;
      rd_pend  <= hsel && htrans[1] && !hwrite;
      bus_addr <= haddr;
    end else begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Pad bits are forced regardless of what software writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      area_width_config <= `EBD_WIDTH_RESET;
    end else if (wr_pend && bus_addr == `EBD_OFS_WIDTH) begin
      area_width_config <= (hwdata[15:0] & `EBD_WIDTH_MASK) | `EBD_WIDTH_FIXED;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_mode_control <= `EBD_MODE_RESET;
    end else if (wr_pend && bus_addr == `EBD_OFS_MODE && VARIANT != EBD_VAR_SMALL) begin
      bus_mode_control <= hwdata[7:0] & `EBD_MODE_MASK;
    end
  end

  // Smallest variant has no mode register, so it always reads multiplexed
  assign separate_mode_select = (VARIANT != EBD_VAR_SMALL) && bus_mode_control[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr == `EBD_OFS_WIDTH) begin
        hrdata <= {16'h0000, area_width_config};
      end else if (haddr == `EBD_OFS_MODE && VARIANT != EBD_VAR_SMALL) begin
        hrdata <= {24'h00_0000, bus_mode_control};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Write alias into the first select block in the smallest variant
  always_comb begin
    eff_addr = cur.addr;
    if (VARIANT == EBD_VAR_SMALL && cur.write && cur.addr <= `EBD_ALIAS_LIM_S) begin
      eff_addr[`EBD_ALIAS_BIT] = 1'b1;
    end
  end

  // Fixed decode, nothing above 16 MB
  always_comb begin
    sel_dec = 4'h0;
    if (cur.valid && !cur.internal && !cur.periph) begin
      unique case (VARIANT)
        EBD_VAR_SMALL: begin
          if (eff_addr >= `EBD_EXT_LO && eff_addr <= `EBD_SEL0_LIM_S) sel_dec[0] = 1'b1;
          if (eff_addr >= `EBD_SEL1_LO_S && eff_addr <= `EBD_SEL1_LIM_S) sel_dec[1] = 1'b1;
        end
        EBD_VAR_TWO: begin
          if (eff_addr <= `EBD_SEL0_LIM_4) sel_dec[0] = 1'b1;
          else if (eff_addr <= `EBD_SEL1_LIM_4) sel_dec[1] = 1'b1;
        end
        default: begin
          if (eff_addr <= `EBD_SEL0_LIM_4) sel_dec[0] = 1'b1;
          else if (eff_addr <= `EBD_SEL1_LIM_4) sel_dec[1] = 1'b1;
          else if (eff_addr <= `EBD_SEL2_LIM_4) sel_dec[2] = 1'b1;
          else if (eff_addr <= `EBD_SEL3_LIM_4) sel_dec[3] = 1'b1;
        end
      endcase
    end
  end

  // Per-area width; peripherals fixed at 16 bits
  always_comb begin
    wide16 = 1'b0;
    if (cur.periph) begin
      wide16 = 1'b1;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (sel_dec[i] && (i < 2 || VARIANT == EBD_VAR_FOUR)) begin
          wide16 = area_width_config[2*i];
        end
      end
    end
    unique case (cur.size)
      2'h0: next_nparts = 2'h0;
      2'h1: next_nparts = wide16 ? 2'h0 : 2'h1;
      default: next_nparts = wide16 ? 2'h1 : 2'h3;
    endcase
  end

  assign cyc_len   = (separate_mode_select ? `EBD_CLK_SEP : `EBD_CLK_MUX)
                     + 3'(WAITS);
  assign part_addr = eff_addr + (wide16 ? {25'h000_0000, part, 1'b0}
                                        : {26'h000_0000, part});
  assign req_ready = (state == ST_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ST_IDLE;
      cur     <= '0;
      part    <= 2'h0;
      nparts  <= 2'h0;
      clk_cnt <= 3'h0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (req.valid) begin
            cur     <= req;
            part    <= 2'h0;
            clk_cnt <= 3'h1;
            state   <= ST_CYC;
          end
        end
        ST_CYC: begin
          nparts <= next_nparts;
          if (cur.internal) begin
            state <= ST_DONE;
          end else if (clk_cnt >= cyc_len) begin
            clk_cnt <= 3'h1;
            if (part == next_nparts) begin
              state <= ST_DONE;
            end else begin
              part <= part + 2'h1;
            end
          end else begin
            clk_cnt <= clk_cnt + 3'h1;
          end
        end
        ST_DONE: begin
          done  <= 1'b1;
          cur   <= '0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Little-endian assembly of read parts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h0000_0000;
    end else if (state == ST_CYC && !cur.internal && !cur.write && clk_cnt >= cyc_len) begin
      if (wide16 && cur.size != 2'h0) begin
        rdata[16*part[0] +: 16] <= ext_data_in;
      end else if (wide16) begin
        rdata[7:0] <= part_addr[0] ? ext_data_in[15:8] : ext_data_in[7:0];
      end else begin
        rdata[8*part +: 8] <= ext_data_in[7:0];
      end
    end
  end

  // Pin drive; internal targets float data and keep strobes idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '{addr: 28'h000_0000, data: 16'h0000, data_oe_n: 1'b1,
                area_select_n: 4'hF, wr_n: 2'h3, rd_n: 1'b1, astb: 1'b0};
    end else if (state == ST_CYC && !cur.internal) begin
      pins.addr          <= part_addr;
      pins.area_select_n <= ~sel_dec;
      pins.astb          <= !separate_mode_select && clk_cnt == 3'h1;
      if (cur.periph) begin
        pins.data_oe_n <= 1'b1;
        pins.wr_n      <= 2'h3;
        pins.rd_n      <= 1'b1;
      end else if (cur.write) begin
        pins.data_oe_n <= 1'b0;
        pins.rd_n      <= 1'b1;
        if (!wide16) begin
          pins.data <= {8'h00, cur.wdata[8*part +: 8]};
          pins.wr_n <= 2'h2;
        end else if (cur.size == 2'h0) begin
          pins.data <= {2{cur.wdata[7:0]}};
          pins.wr_n <= part_addr[0] ? 2'h1 : 2'h2;
        end else begin
          pins.data <= cur.wdata[16*part[0] +: 16];
          pins.wr_n <= 2'h0;
        end
      end else begin
        pins.data_oe_n <= 1'b1;
        pins.wr_n      <= 2'h3;
        pins.rd_n      <= 1'b0;
      end
    end else begin
      pins.data_oe_n     <= 1'b1;
      pins.area_select_n <= 4'hF;
      pins.wr_n          <= 2'h3;
      pins.rd_n          <= 1'b1;
      pins.astb          <= 1'b0;
    end
  end

  width_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend && bus_addr == `EBD_OFS_WIDTH) |=> $stable(area_width_config))
    else $error("width register changed without write");

  width_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (area_width_config & ~`EBD_WIDTH_MASK) == `EBD_WIDTH_FIXED)
    else $error("width pad bits wrong");
  small_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    VARIANT == EBD_VAR_SMALL |-> !separate_mode_select)
    else $error("separate mode in small variant");
  high_nosel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    eff_addr > `EBD_SEL3_LIM_4 |-> sel_dec == 4'h0)
    else $error("select above 16 MB");
  one_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot0(sel_dec))
    else $error("multiple selects");
  periph_wide_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cur.periph |-> wide16)
    else $error("peripheral not 16 bits");
  float_int_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(cur.internal) |-> pins.data_oe_n && pins.wr_n == 2'h3 && pins.rd_n)
    else $error("pins active on internal access");
  first_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == ST_IDLE && req.valid |=> part == 2'h0)
    else $error("split not starting low");
  byte_lane_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins.wr_n[0] && !pins.wr_n[1] |-> $past(cur.size) != 2'h0)
    else $error("byte write on both lanes");
endmodule // ebd_core
`default_nettype wire

// *** src/ebd_defines.svh ***
// Constants for the external bus area decode and sizing block
`ifndef EBD_DEFINES_SVH
`define EBD_DEFINES_SVH
`define EBD_OFS_WIDTH       32'hFFFF_F066
`define EBD_OFS_MODE        32'hFFFF_F068
`define EBD_WIDTH_RESET     16'h5555
`define EBD_WIDTH_FIXED     16'h5500
`define EBD_WIDTH_MASK      16'h0055
`define EBD_MODE_RESET      8'h00
`define EBD_MODE_MASK       8'h01
`define EBD_SEL0_LIM_4      28'h01F_FFFF
`define EBD_SEL1_LIM_4      28'h03F_FFFF
`define EBD_SEL2_LIM_4      28'h07F_FFFF
`define EBD_SEL3_LIM_4      28'h0FF_FFFF
`define EBD_EXT_LO          28'h010_0000
`define EBD_SEL0_LIM_S      28'h010_FFFF
`define EBD_SEL1_LO_S       28'h020_0000
`define EBD_SEL1_LIM_S      28'h020_FFFF
`define EBD_ALIAS_LIM_S     28'h000_FFFF
`define EBD_ALIAS_BIT       20
`define EBD_CLK_MUX         3'h3
`define EBD_CLK_SEP         3'h2
`endif

// *** src/ebd_pkg.sv ***
// Types for the external bus area decode and sizing block
package ebd_pkg;
  typedef enum logic [1:0] {
    EBD_VAR_SMALL = 2'h0,
    EBD_VAR_TWO   = 2'h1,
    EBD_VAR_FOUR  = 2'h2
  } ebd_variant_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;   // 0 byte, 1 half, 2 word
    logic [27:0] addr;
    logic [31:0] wdata;
    logic        periph; // on-chip peripheral target
    logic        internal; // on-chip ROM/RAM target
  } ebd_req_t;
  typedef struct packed {
    logic [27:0] addr;
    logic [15:0] data;
    logic        data_oe_n;
    logic [3:0]  area_select_n;
    logic [1:0]  wr_n;
    logic        rd_n;
    logic        astb;
  } ebd_pins_t;
endpackage

// *** verif/ebd_ext_mem.sv ***
// External memory model seen across the block's bus pins
`timescale 1ns/100ps
`default_nettype none
module ebd_ext_mem (
  input  wire logic               hclk,  // System clock
  input  wire ebd_pkg::ebd_pins_t pins,  // Bus pins from the block
  output logic [15:0]             d_out  // Data driven back
);
  import ebd_pkg::*;
  logic [7:0]  mem [256];
  logic [7:0]  a;
  logic [15:0] last;
  initial last = 16'h0000;
  assign a = pins.addr[7:0];
  // Released bus shows the inverse of the last value, never a stale match
  always_comb begin
    if (!pins.rd_n && pins.area_select_n != 4'hf) d_out = {mem[a | 8'h01], mem[a]};
    else d_out = ~last;
  end
  always_ff @(posedge hclk) begin
    if (!pins.rd_n) last <= d_out;
    if (!pins.wr_n[0]) mem[a] <= pins.data[7:0];
    if (!pins.wr_n[1]) mem[a[0] ? a : a + 8'h01] <= pins.data[15:8];
  end
endmodule // ebd_ext_mem
`default_nettype wire

// *** verif/ext_bus_area_decode_sizing_tb.sv ***
// Self-checking bench for the external bus decode and sizing block
`timescale 1ns/100ps
`default_nettype none
`include "ebd_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module ext_bus_area_decode_sizing_tb;
  import ebd_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, got;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, req_ready, done;
  ebd_req_t    req = '0;
  ebd_pins_t   pins;
  logic [15:0] ext_d;
  logic [27:0] first_a;
  logic [3:0]  sel_seen;
  int          err_count = 0, checked = 0, sel_cyc, n_wr0, n_wr1, n_rd, n_astb;
  logic [27:0] dec_a [8] = '{28'h010_0000, 28'h01F_FFFF, 28'h020_0000, 28'h03F_FFFF,
                            28'h040_0000, 28'h07F_FFFF, 28'h080_0000, 28'h0FF_FFFF};
  int          dec_s [8] = '{0, 0, 1, 1, 2, 2, 3, 3};

  ebd_core #(.VARIANT(EBD_VAR_FOUR), .WAITS(0)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .req(req), .req_ready(req_ready), .done(done), .rdata(rdata),
    .ext_data_in(ext_d), .pins(pins));
  ebd_ext_mem ext_mem (.hclk(hclk), .pins(pins), .d_out(ext_d));

  initial forever #10 hclk = ~hclk;

  // Strobe low cycles counted: a strobe stays low across parts, so parts times clocks
  always @(posedge hclk) begin
    if (pins.area_select_n != 4'hf) begin
      sel_cyc++;
      sel_seen <= pins.area_select_n;
    end
    if (!pins.wr_n[0]) n_wr0++;
    if (!pins.wr_n[1]) n_wr1++;
    if (!pins.rd_n) n_rd++;
    if (pins.astb) n_astb++;
    if (!got && (!pins.rd_n || pins.wr_n != 2'h3)) begin
      first_a <= pins.addr;
      got <= 1'b1;
    end
  end

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic acc(input logic w, input logic [1:0] sz, input logic [27:0] a,
                     input logic [31:0] d, input logic i, input logic p = 1'b0);
    int n;
    @(negedge hclk);
    {sel_cyc, n_wr0, n_wr1, n_rd, n_astb} = '0;
    got = 1'b0;
    sel_seen = 4'hf;
    @(posedge hclk);
    req <= '{valid: 1'b1, write: w, size: sz, addr: a, wdata: d, periph: p, internal: i};
    do @(posedge hclk); while (req_ready !== 1'b1);
    req.valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    `CHK("done", 1'b1, done)
    rd = rdata;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, `EBD_OFS_WIDTH, 0); `CHK("width reset", 32'h0000_5555, rd)
    ahb(0, `EBD_OFS_MODE, 0); `CHK("mode reset", 32'h0000_0000, rd)
    ahb(0, 32'hFFFF_F070, 0); `CHK("unmapped", 32'h0000_0000, rd)
    ahb(1, `EBD_OFS_WIDTH, 32'h0000_5541);
    ahb(0, `EBD_OFS_WIDTH, 0); `CHK("width", 32'h0000_5541, rd)
    ahb(1, `EBD_OFS_MODE, 32'h0000_00FF);
    ahb(0, `EBD_OFS_MODE, 0); `CHK("mode", 32'h0000_0001, rd)
    ahb(1, `EBD_OFS_MODE, 32'h0000_0000);
    $display("test registers done");
    foreach (dec_a[k]) begin
      acc(1, 0, dec_a[k], 32'h0000_0000, 0);
      `CHK("select", ~(4'h1 << dec_s[k]), sel_seen)
      `CHK("mux clocks", 3, sel_cyc)
      `CHK("addr strobe", 1, n_astb)
    end
    acc(1, 0, 28'h100_0000, 32'h0000_0000, 0);
    `CHK("above 16 MB", 0, sel_cyc)
    $display("test decode done");
    acc(1, 2, 28'h010_0010, 32'h4433_2211, 0);
    `CHK("word parts 16", 6, n_wr0)
    `CHK("first part", 28'h010_0010, first_a)
    `CHK("order", 32'h4433_2211, {ext_mem.mem[8'h13], ext_mem.mem[8'h12],
      ext_mem.mem[8'h11], ext_mem.mem[8'h10]})
    acc(1, 2, 28'h020_0020, 32'hDDCC_BBAA, 0);
    `CHK("word parts 8", 12, n_wr0)
    `CHK("high lane 8", 0, n_wr1)
    acc(0, 2, 28'h020_0020, 32'h0000_0000, 0);
    `CHK("read parts 8", 12, n_rd)
    `CHK("read word", 32'hDDCC_BBAA, rd)
    acc(1, 0, 28'h010_0031, 32'h0000_5A5A, 0);
    `CHK("odd lane", 3, n_wr1)
    `CHK("even lane", 0, n_wr0)
    `CHK("odd byte", 8'h5A, ext_mem.mem[8'h31])
    acc(0, 0, 28'h010_0031, 32'h0000_0000, 0);
    `CHK("read odd", 8'h5A, rd[7:0])
    acc(1, 1, 28'h040_0040, 32'h0000_7788, 0);
    `CHK("half parts 8", 6, n_wr0)
    acc(1, 2, 28'h080_0050, 32'h1234_5678, 0);
    `CHK("word parts 3", 6, n_wr0)
    acc(0, 2, 28'h0FF_F100, 32'h0000_0000, 0, 1);
    `CHK("periph sel", 0, sel_cyc)
    `CHK("periph rd", 0, n_rd)
    `CHK("periph addr", 28'h0FF_F102, pins.addr)
    $display("test sizing done");
    acc(0, 2, 28'h000_0100, 32'h0000_0000, 1);
    `CHK("internal sel", 0, sel_cyc)
    `CHK("internal rd", 0, n_rd)
    `CHK("bus float", 1'b1, pins.data_oe_n)
    ahb(1, `EBD_OFS_MODE, 32'h0000_0001);
    acc(1, 0, 28'h010_0060, 32'h0000_00C3, 0);
    `CHK("sep clocks", 2, sel_cyc)
    `CHK("sep no strobe", 0, n_astb)
    $display("test modes done");
    end_of_test();
  end
endmodule // ext_bus_area_decode_sizing_tb
`default_nettype wire
